// *** logic/rct_pkg.sv ***
// Types shared by the reload and capture timer.
// Assumes the constants header is compiled alongside.
`default_nettype none

package rct_pkg;

  // Control register fields, laid out as in the register, bit 7 first.
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_byte_irq_enable;
    logic capture_enable;
    logic split_enable;
    logic run_control;
    logic capture_source_select;
    logic alternate_clock_select;
  } rct_ctrl_t;

  // One access on the special-function-register bus.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rct_sfr_req_t;

  // Per-byte clock selects from the shared clock control register.
  typedef struct packed {
    logic high_byte_clock_select;
    logic low_byte_clock_select;
  } rct_clk_sel_t;

endpackage : rct_pkg

`default_nettype wire

// *** logic/rct_regs.svh ***
// Register offsets, field positions, reset values and divider counts of the
// reload and capture timer.
// Assumes the core's special-function-register bus uses 8-bit addresses.
`ifndef RCT_REGS_SVH
`define RCT_REGS_SVH

// Register addresses on the special-function-register bus.
`define RCT_ADDR_CONTROL 8'hc8
`define RCT_ADDR_RELOAD_LOW 8'hca
`define RCT_ADDR_RELOAD_HIGH 8'hcb
`define RCT_ADDR_COUNT_LOW 8'hcc
`define RCT_ADDR_COUNT_HIGH 8'hcd

// Bit positions inside timer_control.
`define RCT_BIT_HIGH_FLAG 7
`define RCT_BIT_LOW_FLAG 6
`define RCT_BIT_LOW_IRQ_EN 5
`define RCT_BIT_CAPTURE_EN 4
`define RCT_BIT_SPLIT 3
`define RCT_BIT_RUN 2
`define RCT_BIT_CAPTURE_SRC 1
`define RCT_BIT_ALT_CLOCK 0

// Reset values of every register.
`define RCT_RESET_BYTE 8'h00

// Byte wrap points.
`define RCT_BYTE_MAX 8'hff
`define RCT_BYTE_ZERO 8'h00

// Divider end counts: divide by 12 for the core clock, by 8 for the
// external oscillator.
`define RCT_DIV12_LAST 4'hb
`define RCT_DIV8_LAST 3'h7

`endif

// *** logic/rct_timer.sv ***
// Reload and capture timer: two 8-bit count bytes, reload bytes, control.
// Assumes the core drives the register bus on sys_clk, and that the
// external oscillator, start-of-frame and low-frequency oscillator inputs
// come from other clock domains.
//
// Behaviour
// - Unsplit, no capture: 16-bit count; wrap at 0xFFFF loads reload, sets high flag.
// - Unsplit: interrupt on each 16-bit overflow; low wraps too when low enable set.
// - Split, no capture: two 8-bit timers each reloading from its own reload byte.
// - Unsplit: run gates whole timer; split: run gates only the high byte.
// - Split: byte select 1 uses core clock, else divide-12 or external divide-8.
// - External divide-by-8 tick is synchronised to the core clock before use.
// - Split: high flag on high byte wrap, low flag on low byte wrap.
// - Split: interrupt on high wrap; on either wrap when low enable set.
// - Hardware never clears the overflow flags; software clears them by writing.
// - Low flag sets on every low byte wrap in any mode.
// - Capture source bit: 0 start-of-frame, 1 oscillator falling edge.
// - Capture unsplit: free 16-bit count; event copies counts into reload bytes.
// - Capture split: bytes count independently; event copies both into reloads.
// - Interrupt enabled and high flag set requests the timer service routine.
// - Low reload byte is reload value, or captured low count in capture mode.
// - Unsplit: low byte select chooses clock for the whole timer; high ignored.
// - High reload byte is reload value, or captured high count in capture mode.
`include "rct_regs.svh"
`default_nettype none

module rct_timer (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus from the core.
  input wire rct_pkg::rct_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // Clock selects held in the shared clock control register.
  input wire rct_pkg::rct_clk_sel_t clk_sel,
  // Timer interrupt enable from the interrupt controller.
  input wire logic timer_irq_enable,
  // Asynchronous event sources.
  input wire logic ext_osc,
  input wire logic usb_sof,
  input wire logic low_frequency_oscillator,
  // Interrupt request level to the interrupt controller.
  output logic irq_request
);

  // Byte arithmetic used for both count bytes.
  function automatic logic rct_wraps(input logic [7:0] b);
    rct_wraps = (b == `RCT_BYTE_MAX);
  endfunction : rct_wraps

  rct_pkg::rct_ctrl_t ctrl;
  rct_pkg::rct_ctrl_t next_ctrl;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;
  logic [7:0] next_count_low_byte;
  logic [7:0] next_count_high_byte;
  logic [7:0] next_reload_low_byte;
  logic [7:0] next_reload_high_byte;
  logic [7:0] next_sfr_rdata;

  // Synchronisers: three stages each; only stage two feeds stage three.
  logic [2:0] ext_sync;
  logic [2:0] sof_sync;
  logic [2:0] slow_sync;
  logic ext_level;
  logic sof_level;
  logic slow_level;
  logic next_ext_level;
  logic next_sof_level;
  logic next_slow_level;
  logic ext_rise;
  logic sof_strobe;
  logic slow_fall;

  // Dividers.
  logic [3:0] div12_cnt;
  logic [3:0] next_div12_cnt;
  logic [2:0] div8_cnt;
  logic [2:0] next_div8_cnt;
  logic div12_tick;
  logic div8_tick;
  logic alt_tick;

  // Count enables and events.
  logic low_tick;
  logic high_tick;
  logic low_wrap;
  logic high_wrap;
  logic capture_event;
  logic sw_ctrl;
  logic sw_rl;
  logic sw_rh;
  logic sw_cl;
  logic sw_ch;

  // Synchroniser flops for the three foreign inputs.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_sync <= 3'h0;
      sof_sync <= 3'h0;
      slow_sync <= 3'h0;
    end
    else
    begin
      ext_sync <= {ext_sync[1:0], ext_osc};
      sof_sync <= {sof_sync[1:0], usb_sof};
      slow_sync <= {slow_sync[1:0], low_frequency_oscillator};
    end
  end

  // A level is accepted only once stages two and three agree, so a
  // metastable first stage never reaches an edge detector.
  always_comb
  begin
    next_ext_level = (ext_sync[1] == ext_sync[2]) ? ext_sync[2] : ext_level;
    next_sof_level = (sof_sync[1] == sof_sync[2]) ? sof_sync[2] : sof_level;
    next_slow_level = (slow_sync[1] == slow_sync[2]) ? slow_sync[2] : slow_level;
    ext_rise = next_ext_level & ~ext_level;
    sof_strobe = next_sof_level & ~sof_level;
    slow_fall = ~next_slow_level & slow_level;
  end

  // Accepted levels, the reference for edge detection.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_level <= 1'b0;
      sof_level <= 1'b0;
      slow_level <= 1'b0;
    end
    else
    begin
      ext_level <= next_ext_level;
      sof_level <= next_sof_level;
      slow_level <= next_slow_level;
    end
  end

  // Dividers produce one-cycle enables; the external one counts
  // synchronised rising edges, so its rate is limited to under a quarter
  // of sys_clk.
  always_comb
  begin
    div12_tick = (div12_cnt == `RCT_DIV12_LAST);
    next_div12_cnt = div12_tick ? 4'h0 : div12_cnt + 4'h1;
    div8_tick = ext_rise && (div8_cnt == `RCT_DIV8_LAST);
    next_div8_cnt = ext_rise ? div8_cnt + 3'h1 : div8_cnt;
  end

  // Divider state.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      div12_cnt <= 4'h0;
      div8_cnt <= 3'h0;
    end
    else
    begin
      div12_cnt <= next_div12_cnt;
      div8_cnt <= next_div8_cnt;
    end
  end

  // Clock and run selection for each byte.
  always_comb
  begin
    alt_tick = ctrl.alternate_clock_select ? div8_tick : div12_tick;
    if (ctrl.split_enable)
    begin
      low_tick = clk_sel.low_byte_clock_select ? 1'b1 : alt_tick;
      high_tick = ctrl.run_control
        && (clk_sel.high_byte_clock_select ? 1'b1 : alt_tick);
    end
    else
    begin
      // The high byte select is ignored here.
      low_tick = ctrl.run_control
        && (clk_sel.low_byte_clock_select ? 1'b1 : alt_tick);
      high_tick = low_tick && rct_wraps(count_low_byte);
    end
    low_wrap = low_tick && rct_wraps(count_low_byte);
    high_wrap = high_tick && rct_wraps(count_high_byte);
    capture_event = ctrl.capture_enable
      && (ctrl.capture_source_select ? slow_fall : sof_strobe);
  end

  // Register write strobes.
  always_comb
  begin
    sw_ctrl = sfr_req.wr && (sfr_req.addr == `RCT_ADDR_CONTROL);
    sw_rl = sfr_req.wr && (sfr_req.addr == `RCT_ADDR_RELOAD_LOW);
    sw_rh = sfr_req.wr && (sfr_req.addr == `RCT_ADDR_RELOAD_HIGH);
    sw_cl = sfr_req.wr && (sfr_req.addr == `RCT_ADDR_COUNT_LOW);
    sw_ch = sfr_req.wr && (sfr_req.addr == `RCT_ADDR_COUNT_HIGH);
  end

  // Counting, reloading and capture; software writes are applied last so
  // that they win over a hardware update in the same cycle.
  always_comb
  begin
    next_count_low_byte = count_low_byte;
    next_count_high_byte = count_high_byte;
    next_reload_low_byte = reload_low_byte;
    next_reload_high_byte = reload_high_byte;
    if (low_tick)
    begin
      next_count_low_byte = count_low_byte + 8'h01;
    end
    if (high_tick)
    begin
      next_count_high_byte = count_high_byte + 8'h01;
    end
    if (!ctrl.capture_enable)
    begin
      if (ctrl.split_enable)
      begin
        if (low_wrap)
        begin
          next_count_low_byte = reload_low_byte;
        end
        if (high_wrap)
        begin
          next_count_high_byte = reload_high_byte;
        end
      end
      else if (high_wrap)
      begin
        next_count_low_byte = reload_low_byte;
        next_count_high_byte = reload_high_byte;
      end
    end
    else if (capture_event)
    begin
      // Free-running counts wrap to zero; only the event copies them.
      next_reload_low_byte = count_low_byte;
      next_reload_high_byte = count_high_byte;
    end
    if (sw_cl)
    begin
      next_count_low_byte = sfr_req.wdata;
    end
    if (sw_ch)
    begin
      next_count_high_byte = sfr_req.wdata;
    end
    if (sw_rl)
    begin
      next_reload_low_byte = sfr_req.wdata;
    end
    if (sw_rh)
    begin
      next_reload_high_byte = sfr_req.wdata;
    end
  end

  // Control register: software writes every bit, then hardware sets the
  // flags on top, so an event never falls between a read and a clear.
  always_comb
  begin
    next_ctrl = ctrl;
    if (sw_ctrl)
    begin
      next_ctrl = rct_pkg::rct_ctrl_t'(sfr_req.wdata);
    end
    if (high_wrap || capture_event)
    begin
      next_ctrl.high_overflow_flag = 1'b1;
    end
    if (low_wrap)
    begin
      next_ctrl.low_overflow_flag = 1'b1;
    end
  end

  // Read data is registered so the core sees a stable byte.
  always_comb
  begin
    next_sfr_rdata = sfr_rdata;
    if (sfr_req.rd)
    begin
      unique case (sfr_req.addr)
        `RCT_ADDR_CONTROL: next_sfr_rdata = ctrl;
        `RCT_ADDR_RELOAD_LOW: next_sfr_rdata = reload_low_byte;
        `RCT_ADDR_RELOAD_HIGH: next_sfr_rdata = reload_high_byte;
        `RCT_ADDR_COUNT_LOW: next_sfr_rdata = count_low_byte;
        `RCT_ADDR_COUNT_HIGH: next_sfr_rdata = count_high_byte;
        default: next_sfr_rdata = 8'h00;
      endcase
    end
  end

  // Timer state.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= rct_pkg::rct_ctrl_t'(`RCT_RESET_BYTE);
      count_low_byte <= `RCT_RESET_BYTE;
      count_high_byte <= `RCT_RESET_BYTE;
      reload_low_byte <= `RCT_RESET_BYTE;
      reload_high_byte <= `RCT_RESET_BYTE;
      sfr_rdata <= 8'h00;
    end
    else
    begin
      ctrl <= next_ctrl;
      count_low_byte <= next_count_low_byte;
      count_high_byte <= next_count_high_byte;
      reload_low_byte <= next_reload_low_byte;
      reload_high_byte <= next_reload_high_byte;
      sfr_rdata <= next_sfr_rdata;
    end
  end

  // Request is a level built from the sticky flags; it stays up until
  // software clears the flag, since servicing never clears it.
  assign irq_request = timer_irq_enable
    && (ctrl.high_overflow_flag
        || (ctrl.low_overflow_flag && ctrl.low_byte_irq_enable));

endmodule : rct_timer

`default_nettype wire

// *** test/rct_timer_assertions.sv ***
// Port-level checks for the reload and capture timer.
// Assumes it is bound into rct_timer and sees only that module's ports.
`default_nettype none

module rct_assert (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus and clock selects.
  input wire rct_pkg::rct_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire rct_pkg::rct_clk_sel_t clk_sel,
  // Interrupt enable and request.
  input wire logic timer_irq_enable,
  input wire logic irq_request
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] ctl;
  logic [5:0] next_ctl;

  // Only software moves bits 5 to 0, so its last control write predicts them.
  always_comb
  begin
    next_ctl = (sfr_req.wr && sfr_req.addr == 8'hc8) ? sfr_req.wdata[5:0] : ctl;
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ctl <= 6'h00;
    else
      ctl <= next_ctl;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Two back-to-back reads of one place with no write between them.
  sequence s_rd2(a, c);
    (c && sfr_req.rd && !sfr_req.wr && sfr_req.addr == a) [*2];
  endsequence
  property p_step(c);
    s_rd2(8'hcc, c) |=> $past(sfr_rdata) == 8'hff || sfr_rdata == $past(sfr_rdata) + 8'h01;
  endproperty

  a_irq_gated: assert property (!timer_irq_enable |-> !irq_request)
    else $error("request without enable");
  a_flag_sticky: assert property (
    (irq_request && !(sfr_req.wr && sfr_req.addr == 8'hc8)) ##1 timer_irq_enable
    |-> irq_request) else $error("request dropped without clear");
  a_reload_hold: assert property (
    (sfr_req.wr && sfr_req.addr == 8'hca && !ctl[4]) ##1
    (sfr_req.rd && !sfr_req.wr && sfr_req.addr == 8'hca)
    |=> sfr_rdata == $past(sfr_req.wdata, 2)) else $error("reload low lost");
  a_run_stops: assert property (
    s_rd2(8'hcc, ctl[4:2] == 3'b000) |=> $stable(sfr_rdata)) else $error("stopped count moved");
  a_low_steps: assert property (
    p_step(ctl[4:2] == 3'b001 && clk_sel.low_byte_clock_select)) else $error("count step");
  a_split_low: assert property (
    p_step(ctl[4:2] == 3'b010 && clk_sel.low_byte_clock_select)) else $error("low byte step");
  a_split_high: assert property (
    s_rd2(8'hcd, ctl[4:2] == 3'b010) |=> $stable(sfr_rdata)) else $error("high byte moved");
  a_ctrl_shadow: assert property (
    sfr_req.rd && !sfr_req.wr && sfr_req.addr == 8'hc8 |=> sfr_rdata[5:0] == $past(ctl))
    else $error("control bits changed");

  // Main scenarios reached.
  c_capture: cover property (ctl[4] && irq_request);
  c_split: cover property (ctl[3] && $rose(irq_request));
  c_wrap: cover property (ctl[4:3] == 2'b00 && $rose(irq_request));
endmodule : rct_assert

bind rct_timer rct_assert rct_assert_inst (.sys_clk(sys_clk), .rst(rst), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .clk_sel(clk_sel), .timer_irq_enable(timer_irq_enable),
  .irq_request(irq_request));

`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the reload and capture timer.
// Assumes the timer package and checker are compiled before it.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DLY = 2;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  rct_pkg::rct_sfr_req_t sfr_req = '0;
  rct_pkg::rct_clk_sel_t clk_sel = '0;
  logic timer_irq_enable = 1'b0;
  logic ext_osc = 1'b0;
  logic usb_sof = 1'b0;
  logic slow_osc = 1'b1;
  logic [7:0] sfr_rdata;
  logic irq_request;
  logic [7:0] q;
  logic [7:0] rl;
  logic [7:0] rh;
  logic [7:0] regs [5] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd};
  logic [7:0] caps [4] = '{8'h14, 8'h16, 8'h1c, 8'h1e};
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  rct_timer rct_timer_inst (.sys_clk(sys_clk), .rst(rst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .clk_sel(clk_sel), .timer_irq_enable(timer_irq_enable),
    .ext_osc(ext_osc), .usb_sof(usb_sof), .low_frequency_oscillator(slow_osc),
    .irq_request(irq_request));

  // Core clock, and an external oscillator of unrelated period and phase.
  always #12.5 sys_clk = ~sys_clk;
  always #51 ext_osc = ~ext_osc;

  // A hang is cut short; the whole run needs well under this many cycles.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      results();
    end
  end

  // Bus cycles: fields change just after an edge and hold until the next access.
  task automatic step();
    @(posedge sys_clk);
    #DLY;
    q = sfr_rdata;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{1'b1, 1'b0, a, d};
    step();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    sfr_req = '{1'b0, 1'b1, a, 8'h00};
    step();
  endtask : rd
  task automatic idle(input int n);
    sfr_req = '0;
    repeat (n) step();
  endtask : idle

  // Counts one comparison against a range and reports a miss at once.
  task automatic chk(input string what, input logic [7:0] lo, input logic [7:0] hi,
    input logic [7:0] got);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h..%h seen %h", what, lo, hi, got);
    end
  endtask : chk

  // Expected control byte once hardware has set the given overflow flags.
  function automatic logic [7:0] with_flags(input logic [7:0] c, input logic h, input logic l);
    return c | {h, l, 6'h00};
  endfunction : with_flags

  // One event: a frame pulse, or a fall of the slow oscillator.
  task automatic fire(input logic src);
    if (src)
      slow_osc = 1'b0;
    else
      usb_sof = 1'b1;
    idle(3);
    slow_osc = 1'b1;
    usb_sof = 1'b0;
    idle(6);
  endtask : fire

  task automatic results();
    $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // Main sequence.
  initial
  begin
    void'($urandom(97));
    repeat (10) @(posedge sys_clk);
    #DLY;
    rst = 1'b0;
    foreach (regs[i])
    begin
      rd(regs[i]);
      chk("reset value", 8'h00, 8'h00, q);
    end
    wr(8'hc9, 8'h5a);
    rd(8'hc9);
    chk("unmapped", 8'h00, 8'h00, q);
    $display("Test reset done");
    repeat (4)
    begin
      rl = 8'($urandom);
      wr(8'hca, rl);
      rd(8'hca);
      chk("reload low", rl, rl, q);
      wr(8'hcb, ~rl);
      rd(8'hcb);
      chk("reload high", ~rl, ~rl, q);
    end
    $display("Test reload done");
    // The high select is off to show it is ignored when unsplit.
    rl = 8'($urandom_range(224));
    rh = 8'($urandom_range(176));
    wr(8'hca, rl);
    wr(8'hcb, rh);
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    clk_sel = 2'b01;
    timer_irq_enable = 1'b1;
    wr(8'hc8, 8'h04);
    idle(2);
    rd(8'hc8);
    chk("flags at wrap", 8'hc4, 8'hc4, q);
    chk("irq", 8'h01, 8'h01, {7'h00, irq_request});
    rd(8'hcc);
    rd(8'hcc);
    chk("low after reload", rl + 8'h01, rl + 8'h0c, q);
    rd(8'hcd);
    chk("high after reload", rh, rh, q);
    wr(8'hc8, 8'h00);
    idle(1);
    chk("irq cleared", 8'h00, 8'h00, {7'h00, irq_request});
    rd(8'hcc);
    rl = q;
    rd(8'hcc);
    chk("stopped count", rl, rl, q);
    wr(8'hc8, 8'hc0);
    idle(1);
    chk("irq set", 8'h01, 8'h01, {7'h00, irq_request});
    timer_irq_enable = 1'b0;
    idle(1);
    chk("irq masked", 8'h00, 8'h00, {7'h00, irq_request});
    timer_irq_enable = 1'b1;
    $display("Test wrap done");
    rl = 8'($urandom_range(224));
    wr(8'hc8, 8'h08);
    wr(8'hcd, rh);
    wr(8'hca, rl);
    wr(8'hcc, 8'hff);
    idle(2);
    rd(8'hcd);
    rd(8'hcd);
    chk("held high", rh, rh, q);
    rd(8'hc8);
    chk("low flag only", 8'h48, 8'h48, q);
    chk("irq low off", 8'h00, 8'h00, {7'h00, irq_request});
    rd(8'hcc);
    rd(8'hcc);
    chk("split low", rl, rl + 8'h0c, q);
    // The clear lands on the very edge at which the low byte wraps again.
    wr(8'hcc, 8'hfe);
    idle(1);
    wr(8'hc8, 8'h08);
    rd(8'hc8);
    chk("set beats clear", with_flags(8'h08, 1'b0, 1'b1), 8'h48, q);
    wr(8'hc8, 8'h28);
    wr(8'hcc, 8'hff);
    idle(2);
    chk("irq low on", 8'h01, 8'h01, {7'h00, irq_request});
    clk_sel = 2'b11;
    wr(8'hc8, 8'h0c);
    wr(8'hcd, 8'hff);
    idle(2);
    rd(8'hc8);
    chk("high flag", 8'h8c, 8'h8c, q);
    clk_sel = 2'b00;
    wr(8'hc8, 8'h08);
    wr(8'hcc, 8'h00);
    idle(35);
    rd(8'hcc);
    chk("divide by 12", 8'h02, 8'h03, q);
    wr(8'hc8, 8'h09);
    wr(8'hcc, 8'h00);
    idle(79);
    rd(8'hcc);
    chk("external by 8", 8'h01, 8'h03, q);
    $display("Test split done");
    // Capture: each source in both count modes, the other source first.
    foreach (caps[i])
    begin
      clk_sel = 2'b11;
      wr(8'hc8, caps[i]);
      wr(8'hca, 8'hee);
      wr(8'hcd, rh);
      wr(8'hcc, 8'h10);
      fire(~caps[i][1]);
      rd(8'hca);
      chk("no capture", 8'hee, 8'hee, q);
      fire(caps[i][1]);
      rd(8'hca);
      chk("captured low", 8'h18, 8'h38, q);
      rd(8'hcb);
      chk("captured high", rh, caps[i][3] ? rh + 8'h30 : rh, q);
      rd(8'hc8);
      rl = with_flags(caps[i], 1'b1, 1'b0);
      chk("capture flag", rl, rl, q);
      chk("capture irq", 8'h01, 8'h01, {7'h00, irq_request});
    end
    $display("Test capture done");
    results();
  end
endmodule : tb_top

`default_nettype wire
